// ==== common/flash_seq_map.svh ====
// Bus addresses, command codes, status bit positions and timing counts for the flash controller
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define UNLOCK_ADDR1       12'h555
`define UNLOCK_ADDR2       12'h2aa
`define UNLOCK_DATA1       16'h00aa
`define UNLOCK_DATA2       16'h0055
`define CMD_PROGRAM        16'h00a0
`define CMD_BYPASS         16'h0020
`define CMD_BYPASS_RST1    16'h0090
`define CMD_BYPASS_RST2    16'h0000
`define CMD_ERASE_SETUP    16'h0080
`define CMD_CHIP_ERASE     16'h0010
`define CMD_SECTOR_ERASE   16'h0030
`define CMD_SECURE_ENTER   16'h0088
`define CMD_SECURE_EXIT    16'h0090
`define CMD_SECURE_EXIT2   16'h0000
`define CMD_RESET          16'h00f0
`define POLL_BIT           7
`define TOGGLE_BIT         6
`define TIMEOUT_BIT        5
`define WINDOW_BIT         3
`define ERASE_TOGGLE_BIT   2
`define WE_LOW_NS          40
`define WE_HIGH_NS         40
`define CLK_NS             4
`define WE_LOW_CYC         ((`WE_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define WE_HIGH_CYC        ((`WE_HIGH_NS + `CLK_NS - 1) / `CLK_NS)
`define RESET_PULSE_NS     500
`define RESET_PULSE_CYC    ((`RESET_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define ERASE_WINDOW_US    50
`endif

// ==== common/flash_seq_pkg.sv ====
// Types shared by the flash controller
package flash_seq_pkg;
    typedef enum logic [3:0] {
        OP_READ_STATUS = 4'h0,
        OP_PROGRAM     = 4'h1,
        OP_BYPASS_ON   = 4'h2,
        OP_BYPASS_PROG = 4'h3,
        OP_BYPASS_OFF  = 4'h4,
        OP_CHIP_ERASE  = 4'h5,
        OP_SECTOR_ERASE= 4'h6,
        OP_SECTOR_ADD  = 4'h7,
        OP_SECURE_ON   = 4'h8,
        OP_SECURE_OFF  = 4'h9,
        OP_RESET_CMD   = 4'ha,
        OP_HW_RESET    = 4'hb
    } op_e;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_LOW   = 3'b010,
        ST_HIGH  = 3'b011,
        ST_RDLOW = 3'b100,
        ST_HWRST = 3'b101,
        ST_DONE  = 3'b110
    } state_e;
endpackage

// ==== rtl/flash_cmd_host.sv ====
// Host-side controller that issues command sequences to a multi-bank parallel flash
`timescale 1ns/1ps
`include "flash_seq_map.svh"
// Summary of operation
// - Secure region entry is a three-write sequence; region stays mapped until exit; the host also clears secure_active on hardware reset.
// - Secure region exit is a four-write sequence restoring normal array access.
// - Word program: two unlocks, setup, then address with data.
// - Hardware reset aborts program or erase; reissue sequence afterwards.
// - Bypass entry: two unlocks then command 20h.
// - Bypass program: A0h then address with data, repeated freely.
// - In bypass only bypass program and bypass reset; exit with two writes.
// - Chip erase: two unlocks, setup, two unlocks, chip erase command.
// - Sector erase: five sequence writes then sector address with command.
// - Extra sector erase writes must follow within 50 us of the last.
// - Address latched on later falling strobe, data on earlier rising strobe.
// - Reset command is refused while the device is busy; a timed-out operation is only aborted by hardware reset.
module flash_cmd_host
    import flash_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire op_e         req_op,
    input  wire logic [1:0]  req_bank,
    input  wire logic [21:0] req_addr,
    input  wire logic [15:0] req_data,
    output logic             done_valid,
    output logic [15:0]      done_status,
    output logic             refused,
    output logic             bypass_active,
    output logic             secure_active,
    output logic             busy_seen,
    input  wire logic        accel_high,
    output logic [23:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_we_n,
    output logic             flash_oe_n,
    output logic             flash_reset_n,
    input  wire logic        ready_busy_out,
    output logic             write_protect_accel_pin
);
    state_e      st_q, st_d;
    logic [2:0]  idx_q, idx_d;
    logic [2:0]  len_q, len_d;
    logic [7:0]  cnt_q, cnt_d;
    op_e         op_q, op_d;
    logic [1:0]  bank_q, bank_d;
    logic [21:0] addr_q, addr_d;
    logic [15:0] data_q, data_d;
    logic [15:0] stat_q, stat_d;
    logic        done_q, done_d;
    logic        ref_q, ref_d;
    logic        byp_q, byp_d;
    logic        sec_q, sec_d;
    logic [23:0] fa_q, fa_d;
    logic [15:0] fd_q, fd_d;
    logic        oe_q, oe_d;
    logic        ce_q, ce_d;
    logic        we_q, we_d;
    logic        rd_q, rd_d;
    logic        rn_q, rn_d;
    logic [11:0] seq_a;
    logic [15:0] seq_d;
    logic        seq_full;
    logic        allowed;

    // Writes of the chosen sequence: step index to bank-local address and data
    always_comb begin
        seq_full = 1'b0;
        seq_a    = `UNLOCK_ADDR1;
        seq_d    = `UNLOCK_DATA1;
        case (idx_q)
            3'd0: begin
                seq_a = `UNLOCK_ADDR1;
                seq_d = `UNLOCK_DATA1;
            end
            3'd1: begin
                seq_a = `UNLOCK_ADDR2;
                seq_d = `UNLOCK_DATA2;
            end
            default: begin
                seq_a = `UNLOCK_ADDR1;
                seq_d = `UNLOCK_DATA1;
            end
        endcase
        case (op_q)
            OP_PROGRAM: begin
                if (idx_q == 3'd2) seq_d = `CMD_PROGRAM;
                if (idx_q == 3'd3) seq_full = 1'b1;
            end
            OP_BYPASS_ON: begin
                if (idx_q == 3'd2) seq_d = `CMD_BYPASS;
            end
            OP_BYPASS_PROG: begin
                if (idx_q == 3'd0) seq_d = `CMD_PROGRAM;
                if (idx_q == 3'd1) seq_full = 1'b1;
            end
            OP_BYPASS_OFF: begin
                seq_d = (idx_q == 3'd0) ? `CMD_BYPASS_RST1 : `CMD_BYPASS_RST2;
            end
            OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
                if (idx_q == 3'd2) seq_d = `CMD_ERASE_SETUP;
                if (idx_q == 3'd3) begin
                    seq_a = `UNLOCK_ADDR1;
                    seq_d = `UNLOCK_DATA1;
                end
                if (idx_q == 3'd4) begin
                    seq_a = `UNLOCK_ADDR2;
                    seq_d = `UNLOCK_DATA2;
                end
                if (idx_q == 3'd5) begin
                    seq_d    = (op_q == OP_CHIP_ERASE) ? `CMD_CHIP_ERASE : `CMD_SECTOR_ERASE;
                    seq_full = (op_q == OP_SECTOR_ERASE);
                end
            end
            OP_SECTOR_ADD: begin
                seq_d    = `CMD_SECTOR_ERASE;
                seq_full = 1'b1;
            end
            OP_SECURE_ON: begin
                if (idx_q == 3'd2) seq_d = `CMD_SECURE_ENTER;
            end
            OP_SECURE_OFF: begin
                if (idx_q == 3'd2) seq_d = `CMD_SECURE_EXIT;
                if (idx_q == 3'd3) seq_d = `CMD_SECURE_EXIT2;
            end
            default: begin
                seq_d = `CMD_RESET;
            end
        endcase
    end

    // Host-side policing: never send what the device would refuse
    always_comb begin
        allowed = 1'b1;
        if (!ready_busy_out && req_op != OP_READ_STATUS && req_op != OP_HW_RESET &&
            req_op != OP_SECTOR_ADD) allowed = 1'b0;
        if (sec_q && (req_op == OP_BYPASS_ON || req_op == OP_BYPASS_PROG)) allowed = 1'b0;
        if ((byp_q || accel_high) && !(req_op == OP_BYPASS_PROG || req_op == OP_BYPASS_OFF ||
            req_op == OP_READ_STATUS || req_op == OP_HW_RESET)) allowed = 1'b0;
        if (!byp_q && !accel_high && req_op == OP_BYPASS_PROG) allowed = 1'b0;
    end

    assign req_ready = (st_q == ST_IDLE);

    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        len_d = len_q;
        cnt_d = cnt_q;
        op_d = op_q;
        bank_d = bank_q;
        addr_d = addr_q;
        data_d = data_q;
        stat_d = stat_q;
        done_d = 1'b0;
        ref_d = 1'b0;
        byp_d = byp_q;
        sec_d = sec_q;
        fa_d = fa_q;
        fd_d = fd_q;
        oe_d = oe_q;
        ce_d = ce_q;
        we_d = we_q;
        rd_d = rd_q;
        rn_d = 1'b1;
        case (st_q)
            ST_IDLE: begin
                if (req_valid) begin
                    op_d   = req_op;
                    bank_d = req_bank;
                    addr_d = req_addr;
                    data_d = req_data;
                    idx_d  = 3'd0;
                    if (!allowed) begin
                        ref_d = 1'b1;
                    end else if (req_op == OP_HW_RESET) begin
                        cnt_d = 8'(`RESET_PULSE_CYC);
                        st_d  = ST_HWRST;
                    end else if (req_op == OP_READ_STATUS) begin
                        fa_d  = {req_bank, req_addr};
                        ce_d  = 1'b0;
                        rd_d  = 1'b0;
                        cnt_d = 8'(`WE_LOW_CYC);
                        st_d  = ST_RDLOW;
                    end else begin
                        case (req_op)
                            OP_PROGRAM, OP_SECURE_OFF: len_d = 3'd3;
                            OP_BYPASS_ON, OP_SECURE_ON: len_d = 3'd2;
                            OP_BYPASS_PROG, OP_BYPASS_OFF: len_d = 3'd1;
                            OP_CHIP_ERASE, OP_SECTOR_ERASE: len_d = 3'd5;
                            default: len_d = 3'd0;
                        endcase
                        st_d = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                // Address settles before the strobe falls, data drives through the rising edge
                fa_d  = seq_full ? {bank_q, addr_q} : {bank_q, 10'h000, seq_a};
                fd_d  = (seq_full && op_q != OP_SECTOR_ERASE && op_q != OP_SECTOR_ADD) ? data_q : seq_d;
                oe_d  = 1'b1;
                ce_d  = 1'b0;
                cnt_d = 8'(`WE_LOW_CYC);
                st_d  = ST_LOW;
            end
            ST_LOW: begin
                we_d = 1'b0;
                // Strobe falls a cycle after entry, so run to zero to keep it low the full count
                if (cnt_q == 8'd0) begin
                    we_d  = 1'b1;
                    cnt_d = 8'(`WE_HIGH_CYC);
                    st_d  = ST_HIGH;
                end else begin
                    cnt_d = cnt_q - 8'd1;
                end
            end
            ST_HIGH: begin
                ce_d = 1'b1; // CE rises after WE so WE edge latches data
                oe_d = 1'b0;
                if (cnt_q <= 8'd1) begin
                    if (idx_q == len_q) begin
                        st_d = ST_DONE;
                    end else begin
                        idx_d = idx_q + 3'd1;
                        st_d  = ST_LOAD;
                    end
                end else begin
                    cnt_d = cnt_q - 8'd1;
                end
            end
            ST_RDLOW: begin
                // Status bits: poll, toggle, timeout, window, erase toggle
                if (cnt_q <= 8'd1) begin
                    stat_d = flash_dq_in;
                    ce_d   = 1'b1;
                    rd_d   = 1'b1;
                    st_d   = ST_DONE;
                end else begin
                    cnt_d = cnt_q - 8'd1;
                end
            end
            ST_HWRST: begin
                rn_d = 1'b0;
                if (cnt_q <= 8'd1) begin
                    byp_d = 1'b0;
                    sec_d = 1'b0;
                    st_d  = ST_DONE;
                end else begin
                    cnt_d = cnt_q - 8'd1;
                end
            end
            default: begin
                case (op_q)
                    OP_BYPASS_ON:  byp_d = 1'b1;
                    OP_BYPASS_OFF: byp_d = 1'b0;
                    OP_SECURE_ON:  sec_d = 1'b1;
                    OP_SECURE_OFF: sec_d = 1'b0;
                    OP_RESET_CMD:  byp_d = 1'b0;
                    default:       byp_d = byp_q;
                endcase
                done_d = 1'b1;
                st_d   = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
            idx_q <= 3'd0;
            len_q <= 3'd0;
            cnt_q <= 8'h00;
            op_q <= OP_READ_STATUS;
            bank_q <= 2'h0;
            addr_q <= 22'h000000;
            data_q <= 16'h0000;
            stat_q <= 16'h0000;
            done_q <= 1'b0;
            ref_q <= 1'b0;
            byp_q <= 1'b0;
            sec_q <= 1'b0;
            fa_q <= 24'h000000;
            fd_q <= 16'h0000;
            oe_q <= 1'b0;
            ce_q <= 1'b1;
            we_q <= 1'b1;
            rd_q <= 1'b1;
            rn_q <= 1'b1;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            len_q <= len_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            bank_q <= bank_d;
            addr_q <= addr_d;
            data_q <= data_d;
            stat_q <= stat_d;
            done_q <= done_d;
            ref_q <= ref_d;
            byp_q <= byp_d;
            sec_q <= sec_d;
            fa_q <= fa_d;
            fd_q <= fd_d;
            oe_q <= oe_d;
            ce_q <= ce_d;
            we_q <= we_d;
            rd_q <= rd_d;
            rn_q <= rn_d;
        end
    end

    assign done_valid    = done_q;
    assign done_status   = stat_q;
    assign refused       = ref_q;
    assign bypass_active = byp_q | accel_high;
    assign secure_active = sec_q;
    assign busy_seen     = ~ready_busy_out;
    assign flash_addr    = fa_q;
    assign flash_dq_out  = fd_q;
    assign flash_dq_oe   = oe_q;
    assign flash_ce_n    = ce_q;
    assign flash_we_n    = we_q;
    assign flash_oe_n    = rd_q;
    assign flash_reset_n = rn_q;
    // Accel pin held low-voltage side; high voltage is an external supply switch
    assign write_protect_accel_pin = 1'b1;
endmodule // flash_cmd_host

// ==== test/flash_cmd_host_asserts.sv ====
// Port-level assertions for the flash command controller
`timescale 1ns/1ps
module flash_cmd_host_asserts
    import flash_seq_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire op_e         req_op,
    input wire logic        refused,
    input wire logic        done_valid,
    input wire logic        bypass_active,
    input wire logic        secure_active,
    input wire logic        busy_seen,
    input wire logic        accel_high,
    input wire logic [23:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic        flash_dq_oe,
    input wire logic        flash_ce_n,
    input wire logic        flash_we_n,
    input wire logic        flash_reset_n,
    input wire logic        ready_busy_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Own disable so the check survives the last reset cycle
    property p_reset_idle;
        @(posedge clk) disable iff (1'b0) rst |=> flash_ce_n && flash_we_n && flash_reset_n && !flash_dq_oe && !done_valid;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
    property p_hw_pulse;
        $fell(flash_reset_n) |-> (!flash_reset_n)[*8];
    endproperty
    a_hw_pulse: assert property (p_hw_pulse) else $error("reset pulse too short");
    property p_refuse_busy;
        req_valid && req_ready && busy_seen && req_op == OP_PROGRAM |=> refused && flash_ce_n;
    endproperty
    a_refuse_busy: assert property (p_refuse_busy) else $error("program taken while busy");
    property p_secure_no_bypass;
        req_valid && req_ready && secure_active && req_op == OP_BYPASS_ON |=> refused;
    endproperty
    a_secure_no_bypass: assert property (p_secure_no_bypass) else $error("bypass while secure");
    property p_bypass_prog_only;
        req_valid && req_ready && !bypass_active && req_op == OP_BYPASS_PROG |=> refused;
    endproperty
    a_bypass_prog_only: assert property (p_bypass_prog_only) else $error("bypass program outside bypass");
    property p_we_width;
        $fell(flash_we_n) |-> (!flash_we_n)[*8] ##1 (!flash_we_n)[*2] ##1 flash_we_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
    property p_we_setup;
        $fell(flash_we_n) |-> !flash_ce_n && flash_dq_oe && $past(flash_ce_n) == 1'b0;
    endproperty
    a_we_setup: assert property (p_we_setup) else $error("select not ahead of strobe");
    property p_data_hold;
        $rose(flash_we_n) |-> $stable(flash_dq_out) && $stable(flash_addr) && flash_dq_oe && !flash_ce_n;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved at strobe rise");
    property p_busy_no_take;
        !flash_ce_n |-> !req_ready;
    endproperty
    a_busy_no_take: assert property (p_busy_no_take) else $error("ready during bus cycle");
    property p_accel;
        accel_high && req_valid && req_ready && req_op == OP_PROGRAM |=> refused && flash_ce_n;
    endproperty
    a_accel: assert property (p_accel) else $error("full program taken under accel");
    property p_busy_mirror;
        busy_seen == !ready_busy_out;
    endproperty
    a_busy_mirror: assert property (p_busy_mirror) else $error("busy flag wrong");
endmodule // flash_cmd_host_asserts

bind flash_cmd_host flash_cmd_host_asserts u_asserts (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .refused(refused), .done_valid(done_valid),
    .bypass_active(bypass_active), .secure_active(secure_active), .busy_seen(busy_seen),
    .accel_high(accel_high), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n),
    .ready_busy_out(ready_busy_out));

// ==== test/flash_cmd_host_tb_top.sv ====
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`define CHECK_EQ(nm, e, s) begin total_checks++; if ((s) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
module flash_cmd_host_tb_top;
    import flash_seq_pkg::*;
    typedef struct {logic rf; int nw; logic [15:0] msk; logic [15:0] st; logic ldk; logic [15:0] ld;} exp_s;
    exp_s        exp_q[$];
    int          miscompares = 0, total_checks = 0, base = 0, writes;
    logic        clk = 0, rst = 1, req_valid = 0, accel_high = 0;
    op_e         req_op = OP_READ_STATUS;
    logic [1:0]  req_bank = '0;
    logic [21:0] req_addr = '0;
    logic [15:0] req_data = '0, done_status, flash_dq_out, flash_dq_in, last_d;
    logic [23:0] flash_addr;
    logic        req_ready, done_valid, refused, bypass_active, secure_active, busy_seen, flash_dq_oe;
    logic        flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, ready_busy_out;
    flash_cmd_host dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_bank(req_bank), .req_addr(req_addr), .req_data(req_data), .done_valid(done_valid),
        .done_status(done_status), .refused(refused), .bypass_active(bypass_active),
        .secure_active(secure_active), .busy_seen(busy_seen), .accel_high(accel_high), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
        .flash_reset_n(flash_reset_n), .ready_busy_out(ready_busy_out), .write_protect_accel_pin());
    flash_dev_model dev (.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
        .flash_reset_n(flash_reset_n), .hv_accel(accel_high), .flash_dq_in(flash_dq_in),
        .ready_busy_out(ready_busy_out), .writes(writes), .last_d(last_d));
    initial forever #2 clk = ~clk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Each request notes its expected outcome before it is driven
    task automatic issue(input op_e op, input logic rf, input int nw, input logic [15:0] msk = 16'h0000,
                         input logic [15:0] st = 16'h0000, input logic ldk = 1'b0);
        logic [15:0] d;
        d = 16'($urandom());
        exp_q.push_back('{rf, nw, msk, st, ldk, d});
        req_op = op;
        req_addr = 22'($urandom());
        req_bank = 2'($urandom());
        req_data = d;
        req_valid = 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        #1 req_valid = 1'b0;
        while (exp_q.size() != 0) @(posedge clk);
        #1;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 2000 && busy_seen !== 1'b0; i++) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) if (done_valid === 1'b1 || refused === 1'b1) begin
        exp_s e;
        e = exp_q.pop_front();
        `CHECK_EQ("refused", e.rf, refused)
        `CHECK_EQ("writes", e.nw, writes - base)
        `CHECK_EQ("status", e.st, done_status & e.msk)
        if (e.ldk) `CHECK_EQ("data", e.ld, last_d)
        base = writes;
    end
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        conclude();
    end
    initial begin
        void'($urandom(19));
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        issue(OP_READ_STATUS, 0, 0, 16'hffff, 16'hffff);
        repeat (3) begin
            issue(OP_PROGRAM, 0, 4, 16'h0000, 16'h0000, 1'b1);
            issue(OP_PROGRAM, 1, 0);
            wait_idle();
        end
        issue(OP_BYPASS_PROG, 1, 0);
        issue(OP_BYPASS_ON, 0, 3);
        `CHECK_EQ("bypass", 1'b1, bypass_active)
        issue(OP_PROGRAM, 1, 0);
        repeat (2) begin
            issue(OP_BYPASS_PROG, 0, 2, 16'h0000, 16'h0000, 1'b1);
            wait_idle();
        end
        issue(OP_BYPASS_OFF, 0, 2);
        `CHECK_EQ("bypass", 1'b0, bypass_active)
        accel_high = 1'b1;
        issue(OP_PROGRAM, 1, 0);
        issue(OP_BYPASS_PROG, 0, 2, 16'h0000, 16'h0000, 1'b1);
        wait_idle();
        accel_high = 1'b0;
        issue(OP_SECURE_ON, 0, 3);
        `CHECK_EQ("secure", 1'b1, secure_active)
        issue(OP_BYPASS_ON, 1, 0);
        issue(OP_SECURE_OFF, 0, 4);
        `CHECK_EQ("secure", 1'b0, secure_active)
        issue(OP_CHIP_ERASE, 0, 6);
        issue(OP_READ_STATUS, 0, 0, 16'h00ec, 16'h0044);
        issue(OP_SECURE_ON, 1, 0);
        issue(OP_HW_RESET, 0, 0);
        `CHECK_EQ("busy", 1'b0, busy_seen)
        issue(OP_SECTOR_ERASE, 0, 6);
        issue(OP_SECTOR_ADD, 0, 1);
        issue(OP_READ_STATUS, 0, 0, 16'h00ec, 16'h0000);
        repeat (300) @(posedge clk);
        #1;
        issue(OP_READ_STATUS, 0, 0, 16'h00ec, 16'h004c);
        issue(OP_RESET_CMD, 1, 0);
        wait_idle();
        issue(OP_RESET_CMD, 0, 1);
        conclude();
    end
endmodule // flash_cmd_host_tb_top

// ==== test/flash_dev_model.sv ====
// Behavioural flash bank answering the controller's bus cycles
`timescale 1ns/1ps
`include "flash_seq_map.svh"
module flash_dev_model #(
    parameter real PROG_NS  = 400.0,
    parameter real ERASE_NS = 3000.0,
    parameter real WIN_NS   = 1000.0
) (
    input  wire logic [23:0] flash_addr,
    input  wire logic [15:0] flash_dq_out,
    input  wire logic        flash_dq_oe,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_we_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_reset_n,
    input  wire logic        hv_accel,
    output logic [15:0]      flash_dq_in,
    output logic             ready_busy_out,
    output int               writes,
    output logic [15:0]      last_d
);
    logic [11:0] a_lat;
    logic [15:0] rd;
    logic        busy = 0, erasing = 0, in_win = 0, bypass = 0, secure = 0, tog = 0;
    int          ph = 0;
    realtime     t_end, t_win;
    assign ready_busy_out = !busy;
    assign rd = busy ? {8'h00, 1'b0, tog, 2'b00, erasing && !in_win, tog, 2'b00} : 16'hffff;
    // Undriven bus shows the inverse so a stale sample cannot pass
    assign flash_dq_in = (!flash_ce_n && !flash_oe_n && !flash_dq_oe) ? rd : ~rd;
    always @(negedge flash_oe_n) if (busy) tog = !tog;
    always @(negedge flash_we_n) a_lat = flash_addr[11:0];
    always #2 begin
        if (busy && $realtime >= t_end) busy = 0;
        in_win = erasing && busy && $realtime < t_win;
    end
    task automatic start(input realtime dur);
        busy = 1;
        t_end = $realtime + dur;
        ph = 0;
    endtask
    always @(negedge flash_reset_n) begin
        busy = 0;
        erasing = 0;
        ph = 0;
        bypass = 0;
    end
    always @(posedge flash_we_n) if (!flash_ce_n) begin
        writes++;
        last_d = flash_dq_out;
        if (in_win) begin
            if (flash_dq_out == `CMD_SECTOR_ERASE) begin
                t_win = $realtime + WIN_NS;
                t_end = $realtime + ERASE_NS;
            end else busy = 0;
        end else if (busy) ph = 0;
        else if (ph == 9) start(PROG_NS);
        else if ((bypass || hv_accel) && flash_dq_out == `CMD_PROGRAM) ph = 9;
        else if (bypass && flash_dq_out == `CMD_BYPASS_RST1) ph = 8;
        else if (ph == 8) begin
            bypass = flash_dq_out != `CMD_BYPASS_RST2;
            ph = 0;
        end else if (a_lat == `UNLOCK_ADDR1 && flash_dq_out == `UNLOCK_DATA1) ph = (ph == 3) ? 4 : 1;
        else if (a_lat == `UNLOCK_ADDR2 && flash_dq_out == `UNLOCK_DATA2 && (ph == 1 || ph == 4)) ph++;
        else if (ph == 2) begin
            ph = 0;
            case (flash_dq_out)
                `CMD_PROGRAM: ph = 9;
                `CMD_BYPASS: bypass = !secure;
                `CMD_ERASE_SETUP: ph = 3;
                `CMD_SECURE_ENTER: secure = 1;
                `CMD_SECURE_EXIT: ph = 7;
                default: ph = 0;
            endcase
        end else if (ph == 5 && flash_dq_out == `CMD_CHIP_ERASE) start(ERASE_NS);
        else if (ph == 5 && flash_dq_out == `CMD_SECTOR_ERASE) begin
            start(ERASE_NS);
            erasing = 1;
            t_win = $realtime + WIN_NS;
            in_win = 1;
        end else if (ph == 7) begin
            secure = flash_dq_out != `CMD_SECURE_EXIT2;
            ph = 0;
        end else ph = 0;
    end
endmodule // flash_dev_model
